// ==== rtl/gsw_status.sv ====
// gateway status word, control word slot, capture button timer and gateway LED
//
// Behaviour
// - status and control words appear in process data for both protocols.
// - under the first protocol a setting may remove both words from process data.
// - status bit 0 follows any module reporting active diagnosis.
// - status bit 3 set when station module configuration has changed.
// - status bit 6 set while load voltage is above 30 V.
// - status bit 7 set while load voltage is below 18 V.
// - status bit 8 set while system supply is above 30 V.
// - status bit 9 set while system supply is below 18 V.
// - status bit 10 set when the module bus has no communication.
// - status bit 11 set when configuration is no longer compatible.
// - status bit 12 reports the protocol watchdog timeout, only under the second protocol.
// - status bit 14 set while forcing mode is active.
// - control word writes are accepted and have no effect.
// - button held ten seconds stores current configuration as reference.
// - button storage works under the two ethernet protocols, not the third.
// - gateway LED steady green while firmware active and ready.
// - gateway LED flashes green while forcing mode is active.
// - gateway LED flashes green at 4 Hz on hardware error.
// - web access refused after self-disable until factory reset.
`timescale 1ns/1ps
`include "gsw_regs.svh"
module gsw_status #(
	parameter int unsigned HOLD_CYCLES = `GSW_HOLD_S * `GSW_CLK_HZ,
	parameter int unsigned HALF_1HZ = `GSW_CLK_HZ / (2 * `GSW_FLASH_1HZ_HZ),
	parameter int unsigned HALF_4HZ = `GSW_CLK_HZ / (2 * `GSW_FLASH_4HZ_HZ)
) (
	input wire logic sys_clk, // system clock
	input wire logic rst_n, // async reset, active low
	input wire gsw_pkg::gsw_cond_t cond, // live station conditions
	input wire gsw_pkg::gsw_proto_t proto, // active fieldbus protocol
	input wire logic eip_map_disable, // drop words from process data (first protocol)
	input wire logic ctrl_wr, // controller writes control word
	input wire logic [15:0] ctrl_wdata, // control word value
	input wire logic capture_btn, // capture button pressed
	input wire logic fw_ready, // firmware active, gateway ready
	input wire logic hw_error, // hardware error detected
	input wire logic web_self_disable, // web server switched off from itself
	input wire logic factory_reset, // factory reset performed
	output logic [15:0] station_status_word, // status word in process data
	output logic [15:0] station_control_word, // control word slot in process data
	output logic words_mapped, // both words present in process data
	output logic cfg_store, // pulse: store reference configuration
	output gsw_pkg::gsw_led_t gateway_status_led, // gateway LED colour
	output logic web_access_en // web server reachable
);
	// refuse counts that the counters below cannot serve
	if (HOLD_CYCLES < 2 || HALF_1HZ < 1 || HALF_4HZ < 1) begin : g_bad_counts
		$error("gsw_status: counts too small");
	end

	logic [15:0] status_q, status_d;
	logic mapped_q, mapped_d;
	logic [15:0] ctrl_q, ctrl_d;
	logic [31:0] hold_q, hold_d;
	logic armed_q, armed_d;
	logic store_q, store_d;
	logic [31:0] f1_q, f1_d;
	logic [31:0] f4_q, f4_d;
	logic ph1_q, ph1_d;
	logic ph4_q, ph4_d;
	gsw_pkg::gsw_led_t led_q, led_d;
	logic web_q, web_d;
	// helper state for the flash checks: cycles the LED held its value in one mode
	logic [31:0] led_hold_q, led_hold_d;
	logic [1:0] led_mode_q, led_mode_d;

	always_comb begin
		status_d = 16'h0000;
		status_d[`GSW_STAT_DIAG] = cond.module_diag;
		status_d[`GSW_STAT_CFG_WARN] = cond.cfg_changed;
		status_d[`GSW_STAT_OVERCURR] = cond.overcurrent;
		status_d[`GSW_STAT_LOAD_OVER] = cond.load_over;
		status_d[`GSW_STAT_LOAD_UNDER] = cond.load_under;
		status_d[`GSW_STAT_SYS_OVER] = cond.sys_over;
		status_d[`GSW_STAT_SYS_UNDER] = cond.sys_under;
		status_d[`GSW_STAT_MB_LOST] = cond.mbus_lost;
		status_d[`GSW_STAT_CFG_ERR] = cond.cfg_incompat;
		status_d[`GSW_STAT_WDG] = cond.mb_timeout && (proto == gsw_pkg::GSW_PROTO_MBTCP);
		status_d[`GSW_STAT_FORCE] = cond.force_mode;
		// words are mapped for both ethernet protocols, the first may opt out
		case (proto)
			gsw_pkg::GSW_PROTO_EIP: mapped_d = !eip_map_disable;
			gsw_pkg::GSW_PROTO_MBTCP: mapped_d = 1'b1;
			default: mapped_d = 1'b0;
		endcase
	end

	always_comb begin
		// value stored for read-back only; nothing in the block uses it
		ctrl_d = ctrl_wr ? ctrl_wdata : ctrl_q;
	end

	always_comb begin
		hold_d = hold_q;
		armed_d = armed_q;
		store_d = 1'b0;
		if (!capture_btn || proto == gsw_pkg::GSW_PROTO_PNIO) begin
			hold_d = 32'h00000000;
			armed_d = 1'b1;
		end else if (armed_q) begin
			if (hold_q >= HOLD_CYCLES - 1) begin
				store_d = 1'b1;
				armed_d = 1'b0;
				hold_d = 32'h00000000;
			end else begin
				hold_d = hold_q + 32'h00000001;
			end
		end
	end

	always_comb begin
		f1_d = f1_q + 32'h00000001;
		ph1_d = ph1_q;
		if (f1_q >= HALF_1HZ - 1) begin
			f1_d = 32'h00000000;
			ph1_d = !ph1_q;
		end
		f4_d = f4_q + 32'h00000001;
		ph4_d = ph4_q;
		if (f4_q >= HALF_4HZ - 1) begin
			f4_d = 32'h00000000;
			ph4_d = !ph4_q;
		end
		if (!fw_ready)
			led_d = gsw_pkg::GSW_LED_OFF;
		else if (hw_error)
			led_d = ph4_q ? gsw_pkg::GSW_LED_GREEN : gsw_pkg::GSW_LED_OFF;
		else if (cond.force_mode)
			led_d = ph1_q ? gsw_pkg::GSW_LED_GREEN : gsw_pkg::GSW_LED_OFF;
		else
			led_d = gsw_pkg::GSW_LED_GREEN;
	end

	always_comb begin
		// bit 1 marks 4 Hz flashing, bit 0 marks 1 Hz flashing
		led_mode_d = {fw_ready && hw_error, fw_ready && !hw_error && cond.force_mode};
		if (led_d == led_q && led_mode_d == led_mode_q)
			led_hold_d = led_hold_q + 32'h00000001;
		else
			led_hold_d = 32'h00000000;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			led_hold_q <= 32'h00000000;
			led_mode_q <= 2'b00;
		end else begin
			led_hold_q <= led_hold_d;
			led_mode_q <= led_mode_d;
		end
	end

	always_comb begin
		web_d = web_q;
		if (factory_reset)
			web_d = 1'b1;
		else if (web_self_disable)
			web_d = 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_q <= `GSW_STATUS_RESET;
			mapped_q <= 1'b0;
			ctrl_q <= `GSW_CONTROL_RESET;
			hold_q <= 32'h00000000;
			armed_q <= 1'b1;
			store_q <= 1'b0;
			f1_q <= 32'h00000000;
			f4_q <= 32'h00000000;
			ph1_q <= 1'b0;
			ph4_q <= 1'b0;
			led_q <= gsw_pkg::GSW_LED_OFF;
			web_q <= 1'b1;
		end else begin
			status_q <= status_d;
			mapped_q <= mapped_d;
			ctrl_q <= ctrl_d;
			hold_q <= hold_d;
			armed_q <= armed_d;
			store_q <= store_d;
			f1_q <= f1_d;
			f4_q <= f4_d;
			ph1_q <= ph1_d;
			ph4_q <= ph4_d;
			led_q <= led_d;
			web_q <= web_d;
		end
	end

	assign station_status_word = status_q;
	assign station_control_word = ctrl_q;
	assign words_mapped = mapped_q;
	assign cfg_store = store_q;
	assign gateway_status_led = led_q;
	assign web_access_en = web_q;

	a_status_load_over: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cond.load_over |=> station_status_word[`GSW_STAT_LOAD_OVER]) else $error("load over flag missing");
	a_status_sys_under: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cond.sys_under |=> station_status_word[`GSW_STAT_SYS_UNDER]) else $error("sys under flag missing");
	a_status_clears: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!cond.force_mode |=> !station_status_word[`GSW_STAT_FORCE]) else $error("force flag stuck");
	a_status_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(station_status_word & 16'hA016) == 16'h0000) else $error("reserved status bit set");
	// every flag follows its condition one cycle later, set and clear alike
	a_flag_diag: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_DIAG] == $past(cond.module_diag))
		else $error("diag flag wrong");
	a_flag_cfg_warn: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_CFG_WARN] == $past(cond.cfg_changed))
		else $error("config warning flag wrong");
	a_flag_overcurr: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_OVERCURR] == $past(cond.overcurrent))
		else $error("overcurrent flag wrong");
	a_flag_load_over: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_LOAD_OVER] == $past(cond.load_over))
		else $error("load over flag wrong");
	a_flag_load_under: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_LOAD_UNDER] == $past(cond.load_under))
		else $error("load under flag wrong");
	a_flag_sys_over: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_SYS_OVER] == $past(cond.sys_over))
		else $error("sys over flag wrong");
	a_flag_sys_under: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_SYS_UNDER] == $past(cond.sys_under))
		else $error("sys under flag wrong");
	a_flag_mb_lost: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_MB_LOST] == $past(cond.mbus_lost))
		else $error("module bus flag wrong");
	a_flag_cfg_err: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_CFG_ERR] == $past(cond.cfg_incompat))
		else $error("config error flag wrong");
	a_flag_wdg: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_WDG] == $past(cond.mb_timeout && proto == gsw_pkg::GSW_PROTO_MBTCP))
		else $error("watchdog flag wrong");
	a_flag_force: assert property (@(posedge sys_clk) disable iff (!rst_n)
		1'b1 |=> station_status_word[`GSW_STAT_FORCE] == $past(cond.force_mode))
		else $error("force flag wrong");
	// control word is only stored, never acted on
	a_ctrl_write: assert property (@(posedge sys_clk) disable iff (!rst_n)
		ctrl_wr |=> station_control_word == $past(ctrl_wdata))
		else $error("control write lost");
	a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!ctrl_wr |=> $stable(station_control_word))
		else $error("control word changed");
	a_map_eip_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(proto == gsw_pkg::GSW_PROTO_EIP && !eip_map_disable) |=> words_mapped)
		else $error("words not mapped under first protocol");
	a_led_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!fw_ready |=> gateway_status_led == gsw_pkg::GSW_LED_OFF)
		else $error("led lit without firmware");
	a_led_no_red: assert property (@(posedge sys_clk) disable iff (!rst_n)
		gateway_status_led != gsw_pkg::GSW_LED_RED)
		else $error("led red from this block");
	// a flashing LED never holds one value longer than its half period
	a_flash_fast: assert property (@(posedge sys_clk) disable iff (!rst_n)
		led_mode_q == 2'b10 |-> led_hold_q < HALF_4HZ)
		else $error("fast flash too slow");
	a_flash_slow: assert property (@(posedge sys_clk) disable iff (!rst_n)
		led_mode_q == 2'b01 |-> led_hold_q < HALF_1HZ)
		else $error("slow flash too slow");
	a_web_reopen: assert property (@(posedge sys_clk) disable iff (!rst_n)
		factory_reset |=> web_access_en)
		else $error("web not reopened");
	a_web_drop: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(web_self_disable && !factory_reset) |=> !web_access_en)
		else $error("web not closed");
	a_wdg_protocol: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(proto != gsw_pkg::GSW_PROTO_MBTCP) |=> !station_status_word[`GSW_STAT_WDG]) else $error("wdg outside protocol");
	a_map_disable: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(proto == gsw_pkg::GSW_PROTO_EIP && eip_map_disable) |=> !words_mapped) else $error("map not disabled");
	a_map_mbtcp: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(proto == gsw_pkg::GSW_PROTO_MBTCP) |=> words_mapped) else $error("words not mapped");
	a_store_pnio: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(proto == gsw_pkg::GSW_PROTO_PNIO) |=> !cfg_store) else $error("store under third protocol");
	a_store_release: assert property (@(posedge sys_clk) disable iff (!rst_n)
		!capture_btn |=> !cfg_store) else $error("store without press");
	a_store_pulse: assert property (@(posedge sys_clk) disable iff (!rst_n)
		cfg_store |=> !cfg_store) else $error("store longer than a cycle");
	a_led_ready: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(fw_ready && !hw_error && !cond.force_mode) |=> gateway_status_led == gsw_pkg::GSW_LED_GREEN)
		else $error("led not steady green");
	a_web_lock: assert property (@(posedge sys_clk) disable iff (!rst_n)
		(!web_access_en && !factory_reset) |=> !web_access_en) else $error("web reopened");
endmodule : gsw_status

// ==== rtl/gsw_regs.svh ====
// register layout, field positions and timing counts of the gateway status block
`ifndef GSW_REGS_SVH
`define GSW_REGS_SVH
`define GSW_STAT_DIAG 0
`define GSW_STAT_CFG_WARN 3
`define GSW_STAT_OVERCURR 5
`define GSW_STAT_LOAD_OVER 6
`define GSW_STAT_LOAD_UNDER 7
`define GSW_STAT_SYS_OVER 8
`define GSW_STAT_SYS_UNDER 9
`define GSW_STAT_MB_LOST 10
`define GSW_STAT_CFG_ERR 11
`define GSW_STAT_WDG 12
`define GSW_STAT_FORCE 14
`define GSW_STATUS_RESET 16'h0000
`define GSW_CONTROL_RESET 16'h0000
`define GSW_CLK_HZ 10000000
`define GSW_HOLD_S 10
`define GSW_FLASH_1HZ_HZ 1
`define GSW_FLASH_4HZ_HZ 4
`endif

// ==== rtl/gsw_pkg.sv ====
// types shared by the gateway status block
package gsw_pkg;
	typedef enum logic [1:0] {
		GSW_PROTO_EIP,
		GSW_PROTO_MBTCP,
		GSW_PROTO_PNIO
	} gsw_proto_t;
	typedef struct packed {
		logic module_diag;
		logic cfg_changed;
		logic overcurrent;
		logic load_over;
		logic load_under;
		logic sys_over;
		logic sys_under;
		logic mbus_lost;
		logic cfg_incompat;
		logic mb_timeout;
		logic force_mode;
	} gsw_cond_t;
	typedef enum logic [1:0] {
		GSW_LED_OFF,
		GSW_LED_GREEN,
		GSW_LED_RED
	} gsw_led_t;
endpackage : gsw_pkg

// ==== tb/gsw_fieldbus_model.sv ====
// fieldbus controller model writing the reserved control word
`timescale 1ns/1ps
module gsw_fieldbus_model (
	input wire logic sys_clk, // system clock
	output logic ctrl_wr, // control word write strobe
	output logic [15:0] ctrl_wdata // control word value
);
	initial begin
		ctrl_wr = 1'b0;
		ctrl_wdata = 16'h0000;
	end
	task automatic write_ctrl(logic [15:0] d);
		@(negedge sys_clk);
		ctrl_wr = 1'b1;
		ctrl_wdata = d;
		@(negedge sys_clk);
		ctrl_wr = 1'b0;
		ctrl_wdata = ~d;
	endtask : write_ctrl
endmodule : gsw_fieldbus_model

// ==== tb/tb_gateway_status_word_and_indicators.sv ====
// self-checking bench for the gateway status block
`timescale 1ns/1ps
module tb_gateway_status_word_and_indicators;
	typedef struct packed {logic [2:0] k; logic [15:0] e;} gsw_note_t;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	gsw_pkg::gsw_cond_t cond = '0;
	gsw_pkg::gsw_proto_t proto = gsw_pkg::GSW_PROTO_MBTCP;
	logic eip_map_disable = 1'b0, capture_btn = 1'b0, fw_ready = 1'b0, hw_error = 1'b0;
	logic web_self_disable = 1'b0, factory_reset = 1'b0, ctrl_wr, cfg_store, words_mapped, web_access_en;
	logic [15:0] ctrl_wdata, station_status_word, station_control_word, d;
	logic [15:0] flips;
	gsw_pkg::gsw_led_t gateway_status_led, prev;
	int miscompares = 0, total_checks = 0;
	gsw_note_t q[$];
	gsw_note_t n;
	event chk;
	initial forever #50 sys_clk = ~sys_clk;
	gsw_status #(.HOLD_CYCLES(20), .HALF_1HZ(4), .HALF_4HZ(2)) DUT (.sys_clk(sys_clk), .rst_n(rst_n),
		.cond(cond), .proto(proto), .eip_map_disable(eip_map_disable), .ctrl_wr(ctrl_wr),
		.ctrl_wdata(ctrl_wdata), .capture_btn(capture_btn), .fw_ready(fw_ready), .hw_error(hw_error),
		.web_self_disable(web_self_disable), .factory_reset(factory_reset),
		.station_status_word(station_status_word), .station_control_word(station_control_word),
		.words_mapped(words_mapped), .cfg_store(cfg_store), .gateway_status_led(gateway_status_led),
		.web_access_en(web_access_en));
	gsw_fieldbus_model FB (.sys_clk(sys_clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata));
	task automatic tick(int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick
	task automatic measure_flips();
		tick(1);
		flips = 16'h0000;
		prev = gateway_status_led;
		for (int i = 0; i < 8; i++) begin
			tick(1);
			if (gateway_status_led != prev)
				flips++;
			prev = gateway_status_led;
		end
	endtask : measure_flips
	task automatic note(logic [2:0] k, logic [15:0] e);
		q.push_back('{k, e});
		->chk;
	endtask : note
	task automatic cmp_word(string nm, logic [15:0] e, logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %h got %h", nm, e, g);
		end
	endtask : cmp_word
	task automatic cmp_bit(string nm, logic e, logic g);
		total_checks++;
		if (g !== e) begin
			miscompares++;
			$display("MISMATCH %s expected %b got %b", nm, e, g);
		end
	endtask : cmp_bit
	function automatic logic [15:0] exp_status(gsw_pkg::gsw_cond_t c, gsw_pkg::gsw_proto_t p);
		return {1'b0, c.force_mode, 1'b0, c.mb_timeout & (p == gsw_pkg::GSW_PROTO_MBTCP), c.cfg_incompat,
			c.mbus_lost, c.sys_under, c.sys_over, c.load_under, c.load_over, c.overcurrent, 1'b0,
			c.cfg_changed, 2'b00, c.module_diag};
	endfunction : exp_status
	always @(chk) begin
		while (q.size() > 0) begin
			n = q.pop_front();
			case (n.k)
				3'h0: cmp_word("status", n.e, station_status_word);
				3'h1: cmp_word("control", n.e, station_control_word);
				3'h2: cmp_bit("mapped", n.e[0], words_mapped);
				3'h3: cmp_word("led", n.e, {14'h0000, gateway_status_led});
				3'h4: cmp_bit("web", n.e[0], web_access_en);
				3'h6: cmp_word("led flips", n.e, flips);
				default: cmp_bit("store", n.e[0], cfg_store);
			endcase
		end
	end
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : give_verdict
	initial begin
		#(100 * 5000);
		miscompares++;
		give_verdict();
	end
	initial begin
		void'($urandom(32'h4485A01F));
		tick(6);
		rst_n = 1'b1;
		fw_ready = 1'b1;
		tick(2);
		note(3'h4, 16'h0001);
		for (int i = 0; i < 24; i++) begin
			cond = gsw_pkg::gsw_cond_t'(11'($urandom));
			proto = gsw_pkg::gsw_proto_t'(i % 2);
			eip_map_disable = 1'($urandom);
			tick(1);
			note(3'h0, exp_status(cond, proto));
			note(3'h2, {15'h0000, !(proto == gsw_pkg::GSW_PROTO_EIP && eip_map_disable)});
		end
		d = 16'($urandom);
		FB.write_ctrl(d);
		note(3'h1, d);
		note(3'h0, exp_status(cond, proto));
		cond = '0;
		proto = gsw_pkg::GSW_PROTO_MBTCP;
		tick(2);
		note(3'h3, 16'h0001);
		hw_error = 1'b1;
		measure_flips();
		note(3'h6, 16'h0004);
		hw_error = 1'b0;
		cond.force_mode = 1'b1;
		measure_flips();
		note(3'h6, 16'h0002);
		cond.force_mode = 1'b0;
		capture_btn = 1'b1;
		tick(19);
		note(3'h5, 16'h0000);
		tick(1);
		note(3'h5, 16'h0001);
		tick(1);
		note(3'h5, 16'h0000);
		capture_btn = 1'b0;
		tick(1);
		proto = gsw_pkg::GSW_PROTO_PNIO;
		capture_btn = 1'b1;
		tick(22);
		note(3'h5, 16'h0000);
		capture_btn = 1'b0;
		web_self_disable = 1'b1;
		tick(1);
		web_self_disable = 1'b0;
		tick(1);
		note(3'h4, 16'h0000);
		factory_reset = 1'b1;
		tick(1);
		factory_reset = 1'b0;
		fw_ready = 1'b0;
		tick(1);
		note(3'h4, 16'h0001);
		note(3'h3, 16'h0000);
		tick(1);
		give_verdict();
	end
endmodule : tb_gateway_status_word_and_indicators
